// *** bia_consts.svh ***
// constants shared by both ends of the interrupt acknowledge link
`ifndef BIA_CONSTS_SVH
`define BIA_CONSTS_SVH

// widths of the level code, status byte and request bus
`define BIA_LVL_W      3
`define BIA_ID_W       8
`define BIA_IRQ_N      7

// legal request levels, lowest and highest
`define BIA_LVL_MIN    1
`define BIA_LVL_MAX    7

// level a released line floats to (pull-ups on the backplane); request enables all off
`define BIA_ADDR_IDLE  3'h7
`define BIA_DATA_IDLE  8'hff
`define BIA_IRQ_IDLE   7'h00

// state vector widths (one-hot)
`define BIA_IST_W      4
`define BIA_HST_W      6

`endif

// *** bia_pkg.sv ***
// types shared by the interrupter and the interrupt handler
`default_nettype none
`include "bia_consts.svh"

package bia_pkg;

    // interrupter states, one-hot
    typedef enum logic [`BIA_IST_W-1:0] {
        I_IDLE = 4'h1,  // nothing requested
        I_PEND = 4'h2,  // request line held low
        I_DATA = 4'h4,  // status byte on the data lines
        I_DTK  = 4'h8   // dtack low, waiting for ds0 release
    } bia_intr_st_e;

    // handler states, one-hot
    typedef enum logic [`BIA_HST_W-1:0] {
        H_IDLE  = 6'h01,  // watching request lines
        H_REQ   = 6'h02,  // asking requester for the bus
        H_STRB  = 6'h04,  // address, iack and strobe out, ds0 next
        H_WAIT  = 6'h08,  // ds0 low, waiting for dtack
        H_ASREL = 6'h10,  // all lines freed except address strobe
        H_DONE  = 6'h20   // waiting for dtack to rise
    } bia_hndl_st_e;

endpackage

`default_nettype wire

// *** bia_bus_if.sv ***
// backplane wires between one interrupter and one interrupt handler
`timescale 1ns/1ps
`default_nettype none
`include "bia_consts.svh"

interface bia_bus_if;
    // interrupter side drives
    logic [`BIA_IRQ_N:1]  irq_oe;     // pull request line low
    logic [`BIA_ID_W-1:0] data_o;     // status byte
    logic                 data_oe;    // drive low data lines
    logic                 dtack_oe;   // pull dtack low
    logic                 iackout_n;  // daisy chain toward next slot
    // handler side drives
    logic                 dtb_oe;     // drive iack, addr, write, ds0
    logic                 as_oe;      // drive address strobe
    logic                 iack_n_o;
    logic                 as_n_o;
    logic                 ds0_n_o;
    logic                 ds1_n_o;
    logic                 write_n_o;
    logic [3:1]           addr_o;
    // resolved wire levels, released lines float high
    logic [`BIA_IRQ_N:1]  irq_n;
    logic [`BIA_ID_W-1:0] data;
    logic                 dtack_n;
    logic                 iack_n;
    logic                 iackin_n;
    logic                 as_n;
    logic                 ds0_n;
    logic                 ds1_n;
    logic                 write_n;
    logic [3:1]           addr;

    // open-drain request and dtack lines
    assign irq_n    = ~irq_oe;
    assign dtack_n  = ~dtack_oe;
    assign data     = data_oe ? data_o : `BIA_DATA_IDLE;
    // handler-driven lines
    assign iack_n   = dtb_oe ? iack_n_o : 1'b1;
    assign ds0_n    = dtb_oe ? ds0_n_o : 1'b1;
    assign ds1_n    = dtb_oe ? ds1_n_o : 1'b1;
    assign write_n  = dtb_oe ? write_n_o : 1'b1;
    assign addr     = dtb_oe ? addr_o : `BIA_ADDR_IDLE;
    assign as_n     = as_oe ? as_n_o : 1'b1;
    // interrupter sits in the first slot: iack feeds its daisy input
    assign iackin_n = iack_n;

    modport intr (
        output irq_oe, data_o, data_oe, dtack_oe, iackout_n,
        input  iack_n, iackin_n, as_n, ds0_n, addr
    );

    modport hndl (
        output dtb_oe, as_oe, iack_n_o, as_n_o, ds0_n_o, ds1_n_o,
        output write_n_o, addr_o,
        input  irq_n, data, dtack_n
    );
endinterface

`default_nettype wire

// *** bia_interrupter.sv ***
// interrupter end: raises one request level, answers its acknowledge
`timescale 1ns/1ps
`default_nettype none
`include "bia_consts.svh"

module bia_interrupter
    import bia_pkg::*;
#(
    parameter int unsigned LEVEL = 4  // request line this module uses
)(
    input  wire logic                 core_clk,
    input  wire logic                 reset,
    bia_bus_if.intr                   bus,
    input  wire logic                 req_set,
    input  wire logic [`BIA_ID_W-1:0] status_id,
    output logic                      req_pending,
    output logic                      ack_done
);

    // a level outside 1..7 has no request line
    if (LEVEL < `BIA_LVL_MIN || LEVEL > `BIA_LVL_MAX)
    begin : g_bad_level
        $error("interrupter level out of range");
    end

    // level code expected on the low address lines
    localparam logic [`BIA_LVL_W-1:0] LVL_CODE = 3'(LEVEL);
    // one bit set on our own request line
    localparam logic [`BIA_IRQ_N:1]   IRQ_MASK = 7'(1 << (LEVEL - 1));

    // whole state of the interrupter
    typedef struct packed {
        bia_intr_st_e         st;         // sequence state
        logic                 irq_on;     // request line pulled low
        logic [`BIA_ID_W-1:0] id;         // byte to hand over
        logic                 data_oe;    // byte on the bus
        logic                 dtack_oe;   // dtack pulled low
        logic                 iackout_n;  // daisy output level
        logic                 done;       // one-cycle acknowledge pulse
    } bia_intr_s;

    bia_intr_s r_reg;   // registered state
    bia_intr_s r_next;  // next state

    // next state
    always_comb
    begin
        logic hit;
        logic match;
        // the address modifier lines are not even wired in here;
        // an acknowledge is recognised by iack, address strobe and iackin all low
        // iack marks acknowledge
        hit = !bus.iack_n && !bus.as_n && !bus.iackin_n;
        match = (bus.addr == LVL_CODE);
        r_next = r_reg;
        r_next.done = 1'b0;
        r_next.iackout_n = 1'b1;
        unique case (r_reg.st)
            I_IDLE:
            begin
                // nothing pending: any acknowledge is someone else's
                // pass chain downstream
                if (hit)
                    r_next.iackout_n = 1'b0;
                if (req_set)
                begin
                    r_next.st     = I_PEND;
                    r_next.irq_on = 1'b1;
                    r_next.id     = status_id;
                end
            end
            I_PEND:
            begin
                if (hit && match && !bus.ds0_n)
                begin
                    r_next.st      = I_DATA;
                    r_next.data_oe = 1'b1;
                    r_next.irq_on  = 1'b0;
                end
                // wrong level: not ours, let it through
                // pass chain on mismatch
                else if (hit && !match)
                    r_next.iackout_n = 1'b0;
            end
            I_DATA:
            begin
                // byte has had a cycle to settle
                // dtack marks byte valid
                r_next.st       = I_DTK;
                r_next.dtack_oe = 1'b1;
            end
            I_DTK:
            begin
                // ds1 and write are never looked at here
                // only ds0 watched
                if (bus.ds0_n)
                begin
                    r_next.st       = I_IDLE;
                    r_next.data_oe  = 1'b0;
                    r_next.dtack_oe = 1'b0;
                    r_next.done     = 1'b1;
                end
            end
        endcase
    end

    // state register
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            r_reg.st        <= I_IDLE;
            r_reg.irq_on    <= 1'b0;
            r_reg.id        <= '0;
            r_reg.data_oe   <= 1'b0;
            r_reg.dtack_oe  <= 1'b0;
            r_reg.iackout_n <= 1'b1;
            r_reg.done      <= 1'b0;
        end
        else
            r_reg <= r_next;
    end

    // bus and user outputs, all from the state register
    assign bus.irq_oe    = r_reg.irq_on ? IRQ_MASK : `BIA_IRQ_IDLE;
    assign bus.data_o    = r_reg.id;
    assign bus.data_oe   = r_reg.data_oe;
    assign bus.dtack_oe  = r_reg.dtack_oe;
    assign bus.iackout_n = r_reg.iackout_n;
    assign req_pending   = r_reg.irq_on;
    assign ack_done      = r_reg.done;

endmodule

`default_nettype wire

// *** bia_handler.sv ***
// interrupt handler end: ranks requests, runs the acknowledge read
`timescale 1ns/1ps
`default_nettype none
`include "bia_consts.svh"

module bia_handler
    import bia_pkg::*;
#(
    parameter int unsigned LO_LEVEL = 1,  // lowest level serviced
    parameter int unsigned HI_LEVEL = 7   // highest level serviced
)(
    input  wire logic                  core_clk,
    input  wire logic                  reset,
    bia_bus_if.hndl                    bus,
    input  wire logic                  bus_grant,
    output logic                       bus_req,
    output logic [`BIA_LVL_W-1:0]      ack_level,
    output logic [`BIA_ID_W-1:0]       status_id,
    output logic                       id_valid
);

    // the serviced range must be a contiguous slice of 1..7
    if (LO_LEVEL < `BIA_LVL_MIN || HI_LEVEL > `BIA_LVL_MAX ||
        LO_LEVEL > HI_LEVEL)
    begin : g_bad_range
        $error("handler level range invalid");
    end

    // whole state of the handler
    typedef struct packed {
        bia_hndl_st_e          st;       // sequence state
        logic                  bus_req;  // to our requester
        logic                  dtb_oe;   // drive iack/addr/write/ds0
        logic                  as_oe;    // drive address strobe
        logic                  iack_n;   // iack level when driven
        logic                  as_n;     // strobe level when driven
        logic                  ds0_n;    // ds0 level when driven
        logic                  write_n;  // write level when driven
        logic [`BIA_LVL_W-1:0] lvl;      // level being acknowledged
        logic [`BIA_ID_W-1:0]  id;       // latched status byte
        logic                  valid;    // one-cycle byte pulse
    } bia_hndl_s;

    bia_hndl_s r_reg;   // registered state
    bia_hndl_s r_next;  // next state

    // highest active line inside our range; msb flags any hit.
    // the loop climbs upward so the last hit, the top one, wins
    function automatic logic [`BIA_LVL_W:0] pick_top(
        input logic [`BIA_IRQ_N:1] lines_n
    );
        logic [`BIA_LVL_W:0] res;
        res = '0;
        for (int i = LO_LEVEL; i <= HI_LEVEL; i++)
        begin
            if (!lines_n[i])
                res = {1'b1, 3'(i)};
        end
        return res;
    endfunction

    // next state
    always_comb
    begin
        logic [`BIA_LVL_W:0] top;
        top = pick_top(bus.irq_n);
        r_next = r_reg;
        r_next.valid = 1'b0;
        unique case (r_reg.st)
            H_IDLE:
            begin
                // any request in range: go for the bus
                // request bus first
                if (top[`BIA_LVL_W])
                begin
                    r_next.st      = H_REQ;
                    r_next.bus_req = 1'b1;
                end
            end
            H_REQ:
            begin
                // ranking is redone at grant time, so a higher level
                // arriving while we wait for the bus is served first
                // nothing driven before grant
                if (bus_grant && top[`BIA_LVL_W])
                begin
                    r_next.st      = H_STRB;
                    r_next.lvl     = top[`BIA_LVL_W-1:0];
                    r_next.dtb_oe  = 1'b1;
                    r_next.as_oe   = 1'b1;
                    r_next.iack_n  = 1'b0;
                    r_next.as_n    = 1'b0;
                    r_next.write_n = 1'b1;
                    r_next.ds0_n   = 1'b1;
                end
                // request vanished before the grant: give bus back
                else if (bus_grant)
                begin
                    r_next.st      = H_IDLE;
                    r_next.bus_req = 1'b0;
                end
            end
            H_STRB:
            begin
                // address, iack and strobe went out together one cycle ago
                // ds0 low for the byte
                r_next.st    = H_WAIT;
                r_next.ds0_n = 1'b0;
            end
            H_WAIT:
            begin
                // no timeout: a missing interrupter hangs the bus,
                // which the system bus timer must catch
                if (!bus.dtack_n)
                begin
                    r_next.st     = H_ASREL;
                    r_next.id     = bus.data;
                    r_next.valid  = 1'b1;
                    r_next.dtb_oe = 1'b0;
                    r_next.iack_n = 1'b1;
                    r_next.ds0_n  = 1'b1;
                end
            end
            H_ASREL:
            begin
                // every other line already floats high
                // strobe released last
                r_next.st      = H_DONE;
                r_next.as_oe   = 1'b0;
                r_next.as_n    = 1'b1;
                r_next.bus_req = 1'b0;
            end
            H_DONE:
            begin
                if (bus.dtack_n)
                    r_next.st = H_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            r_reg.st      <= H_IDLE;
            r_reg.bus_req <= 1'b0;
            r_reg.dtb_oe  <= 1'b0;
            r_reg.as_oe   <= 1'b0;
            r_reg.iack_n  <= 1'b1;
            r_reg.as_n    <= 1'b1;
            r_reg.ds0_n   <= 1'b1;
            r_reg.write_n <= 1'b1;
            r_reg.lvl     <= '0;
            r_reg.id      <= '0;
            r_reg.valid   <= 1'b0;
        end
        else
            r_reg <= r_next;
    end

    // address lines carry only the level code, upper lines
    // and modifiers are left undriven
    // only three address lines
    assign bus.addr_o    = r_reg.lvl;
    assign bus.dtb_oe    = r_reg.dtb_oe;
    assign bus.as_oe     = r_reg.as_oe;
    assign bus.iack_n_o  = r_reg.iack_n;
    assign bus.as_n_o    = r_reg.as_n;
    assign bus.ds0_n_o   = r_reg.ds0_n;
    assign bus.ds1_n_o   = 1'b1;
    assign bus.write_n_o = r_reg.write_n;

    // user side, all from the state register
    assign bus_req   = r_reg.bus_req;
    assign ack_level = r_reg.lvl;
    assign status_id = r_reg.id;
    assign id_valid  = r_reg.valid;

endmodule

`default_nettype wire

// *** bia_link_asserts.sv ***
// assertion checker watching the wires of the acknowledge link
`timescale 1ns/1ps
`default_nettype none

module bia_link_asserts #(
    parameter int unsigned LEVEL = 4  // level the interrupter requests
)(
    input wire logic       core_clk,
    input wire logic       reset,
    input wire logic [7:1] irq_oe,
    input wire logic       data_oe,
    input wire logic       dtack_oe,
    input wire logic       iackout_n,
    input wire logic       dtb_oe,
    input wire logic       as_oe,
    input wire logic       iack_n_o,
    input wire logic       as_n_o,
    input wire logic       ds0_n_o,
    input wire logic       ds1_n_o,
    input wire logic       write_n_o,
    input wire logic [3:1] addr_o,
    input wire logic       iack_n,
    input wire logic       iackin_n,
    input wire logic       as_n,
    input wire logic       ds0_n,
    input wire logic [3:1] addr
);
    // the only request bit this interrupter may pull
    localparam logic [7:1] LVL_MASK = 7'h01 << (LEVEL - 1);

    // one clock domain, reset disables every check
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    // acknowledge aimed at this interrupter
    sequence s_match;
        !iack_n && !as_n && !iackin_n && !ds0_n && addr == LEVEL
            && irq_oe[LEVEL];
    endsequence
    // byte goes out a cycle ahead of dtack
    sequence s_answer;
        data_oe && !dtack_oe ##1 data_oe && dtack_oe;
    endsequence

    a_one_req_line: assert property ((irq_oe & ~LVL_MASK) == 7'h00)
        else $error("request on a foreign level");
    a_match_answer: assert property (s_match |=> s_answer)
        else $error("acknowledge match not answered in order");
    a_req_until_ack: assert property ($fell(irq_oe[LEVEL]) |-> data_oe)
        else $error("request dropped without acknowledge");
    a_iack_answer: assert property ($rose(data_oe) |-> !$past(iack_n))
        else $error("byte driven without iack low");
    a_dtack_hold: assert property (dtack_oe && !ds0_n |=> dtack_oe)
        else $error("dtack released before data strobe");
    a_chain_idle: assert property (iack_n && $past(iack_n) |-> iackout_n)
        else $error("daisy output low with iack high");
    a_read_strobes: assert property (dtb_oe |-> write_n_o && ds1_n_o)
        else $error("write or ds1 low during acknowledge");
    a_strobe_start: assert property ($rose(as_oe) |->
        dtb_oe && !iack_n_o && !as_n_o ##1 !ds0_n_o)
        else $error("acknowledge start out of order");
    a_as_last: assert property ($fell(dtb_oe) |-> as_oe ##1 !as_oe)
        else $error("address strobe not released last");
    a_level_code: assert property (dtb_oe |-> addr_o == LEVEL)
        else $error("wrong level code on address lines");
endmodule

`default_nettype wire

// *** tb_bus_interrupter_ack.sv ***
// testbench joining interrupter and handler, plus a lone interrupter
`timescale 1ns/1ps
`default_nettype none

module tb_bus_interrupter_ack;
    logic       core_clk;       // 100 MHz
    logic       reset;          // async, active high
    logic       req_set;        // main interrupter request pulse
    logic       req_set_2;      // lone interrupter request pulse
    logic [7:0] stat;           // byte for main interrupter
    logic [7:0] stat_2;         // byte for lone interrupter
    logic       req_pending;
    logic       req_pending_2;
    logic       ack_done;
    logic       ack_done_2;
    logic       bus_grant;      // requester stand-in
    logic       bus_req;
    logic [2:0] ack_level;
    logic [7:0] status_id;
    logic       id_valid;
    logic       bus_grant_2;    // requester stand-in, subset handler
    logic       bus_req_2;
    logic [2:0] ack_level_2;
    logic [7:0] status_id_2;
    int         num_errors;
    int         checks;
    int         cycles;

    bia_bus_if bus1 ();
    bia_bus_if bus2 ();
    bia_bus_if bus3 ();

    bia_interrupter #(.LEVEL(4)) u_bia_interrupter (
        .core_clk(core_clk), .reset(reset), .bus(bus1.intr),
        .req_set(req_set), .status_id(stat),
        .req_pending(req_pending), .ack_done(ack_done));
    bia_handler #(.LO_LEVEL(1), .HI_LEVEL(7)) u_bia_handler (
        .core_clk(core_clk), .reset(reset), .bus(bus1.hndl),
        .bus_grant(bus_grant), .bus_req(bus_req), .ack_level(ack_level),
        .status_id(status_id), .id_valid(id_valid));
    // second interrupter: the bench plays a rule-breaking handler
    bia_interrupter #(.LEVEL(4)) u_bia_interrupter_2 (
        .core_clk(core_clk), .reset(reset), .bus(bus2.intr),
        .req_set(req_set_2), .status_id(stat_2),
        .req_pending(req_pending_2), .ack_done(ack_done_2));
    // subset handler on levels 2..5: the bench plays the interrupters
    bia_handler #(.LO_LEVEL(2), .HI_LEVEL(5)) u_bia_handler_2 (
        .core_clk(core_clk), .reset(reset), .bus(bus3.hndl),
        .bus_grant(bus_grant_2), .bus_req(bus_req_2),
        .ack_level(ack_level_2), .status_id(status_id_2), .id_valid());
    bia_link_asserts #(.LEVEL(4)) u_bia_link_asserts (
        .core_clk(core_clk), .reset(reset), .irq_oe(bus1.irq_oe),
        .data_oe(bus1.data_oe), .dtack_oe(bus1.dtack_oe),
        .iackout_n(bus1.iackout_n), .dtb_oe(bus1.dtb_oe),
        .as_oe(bus1.as_oe), .iack_n_o(bus1.iack_n_o),
        .as_n_o(bus1.as_n_o), .ds0_n_o(bus1.ds0_n_o),
        .ds1_n_o(bus1.ds1_n_o), .write_n_o(bus1.write_n_o),
        .addr_o(bus1.addr_o), .iack_n(bus1.iack_n),
        .iackin_n(bus1.iackin_n), .as_n(bus1.as_n),
        .ds0_n(bus1.ds0_n), .addr(bus1.addr));

    // free-running clock
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // hang guard, well past the 65 or so cycles needed
    always @(posedge core_clk)
    begin
        cycles = cycles + 1;
        if (cycles == 3000)
        begin
            num_errors = num_errors + 1;
            report_and_stop();
        end
    end

    // one comparison; the if prints its own line
    task automatic check(input logic ok, input string msg);
        checks = checks + 1;
        if (!ok)
        begin
            num_errors = num_errors + 1;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask

    // one-cycle request pulse on the main interrupter
    task automatic raise(input logic [7:0] id);
        @(negedge core_clk);
        req_set = 1'b1;
        stat = id;
        @(negedge core_clk);
        req_set = 1'b0;
    endtask

    // grant the bus, collect the byte, hold grant till bus_req drops
    task automatic serve(output logic [7:0] got, output logic done);
        int n;
        for (n = 0; n < 20 && bus_req !== 1'b1; n++)
            @(negedge core_clk);
        bus_grant = 1'b1;
        for (n = 0; n < 40 && id_valid !== 1'b1; n++)
            @(negedge core_clk);
        check(id_valid === 1'b1, "no byte strobe");
        got = status_id;
        for (n = 0; n < 10 && ack_done !== 1'b1; n++)
            @(negedge core_clk);
        done = ack_done;
        for (n = 0; n < 10 && bus_req !== 1'b0; n++)
            @(negedge core_clk);
        bus_grant = 1'b0;
        repeat (2) @(negedge core_clk);
    endtask

    // full acknowledge of level four
    task automatic t_single(input logic [7:0] id);
        logic [7:0] got;
        logic       done;
        raise(id);
        check(req_pending === 1'b1, "request not pending");
        check(bus1.irq_n === 7'h77, "wrong request line low");
        serve(got, done);
        check(got === id, "status byte differs");
        check(ack_level === 3'h4, "wrong level acknowledged");
        check(done === 1'b1, "acknowledge never completed");
        check(req_pending === 1'b0, "request left pending");
        check(bus_req === 1'b0, "bus request left on");
        $display("test single done");
    endtask

    // second request while pending is ignored
    task automatic t_refuse;
        logic [7:0] got;
        logic       done;
        raise(8'h11);
        raise(8'h22);
        serve(got, done);
        check(got === 8'h11, "busy request replaced byte");
        check(done === 1'b1, "acknowledge never completed");
        $display("test refuse done");
    endtask

    // bench handler: mismatch, iack high, then a proper match
    task automatic t_chain;
        int n;
        @(negedge core_clk);
        req_set_2 = 1'b1;
        stat_2 = 8'h3c;
        @(negedge core_clk);
        req_set_2 = 1'b0;
        bus2.dtb_oe = 1'b1;
        bus2.as_oe = 1'b1;
        bus2.as_n_o = 1'b0;
        bus2.ds0_n_o = 1'b0;
        bus2.iack_n_o = 1'b0;
        bus2.addr_o = 3'h3;
        repeat (2) @(negedge core_clk);
        check(bus2.iackout_n === 1'b0, "chain not passed");
        check(bus2.data_oe === 1'b0, "answered foreign level");
        bus2.iack_n_o = 1'b1;
        bus2.addr_o = 3'h4;
        repeat (2) @(negedge core_clk);
        check(bus2.data_oe === 1'b0, "answered with iack high");
        check(bus2.iackout_n === 1'b1, "chain low, iack high");
        // write and ds1 low must not matter to the interrupter
        bus2.write_n_o = 1'b0;
        bus2.ds1_n_o = 1'b0;
        bus2.iack_n_o = 1'b0;
        @(negedge core_clk);
        check(bus2.data_oe === 1'b1, "no byte on match");
        check(bus2.dtack_oe === 1'b0, "dtack ahead of byte");
        @(negedge core_clk);
        check(bus2.dtack_oe === 1'b1, "no dtack");
        check(bus2.data === 8'h3c, "wrong byte on data");
        check(req_pending_2 === 1'b0, "request kept");
        bus2.dtb_oe = 1'b0;
        bus2.as_oe = 1'b0;
        for (n = 0; n < 5 && ack_done_2 !== 1'b1; n++)
            @(negedge core_clk);
        check(ack_done_2 === 1'b1, "no completion");
        check(bus2.dtack_oe === 1'b0, "dtack stuck");
        // same acknowledge again, now with nothing pending
        bus2.dtb_oe = 1'b1;
        bus2.as_oe = 1'b1;
        repeat (2) @(negedge core_clk);
        check(bus2.iackout_n === 1'b0, "idle module kept chain");
        check(bus2.data_oe === 1'b0, "idle module answered");
        bus2.dtb_oe = 1'b0;
        bus2.as_oe = 1'b0;
        $display("test chain done");
    endtask

    // bench interrupter on bus3: grant, answer the level code, release
    task automatic serve_subset(output logic [2:0] lvl);
        int n;
        for (n = 0; n < 20 && bus_req_2 !== 1'b1; n++)
            @(negedge core_clk);
        bus_grant_2 = 1'b1;
        for (n = 0; n < 20 && bus3.ds0_n !== 1'b0; n++)
            @(negedge core_clk);
        lvl = bus3.addr;
        bus3.data_o = {5'h18, bus3.addr};
        bus3.data_oe = 1'b1;
        bus3.dtack_oe = 1'b1;
        bus3.irq_oe[bus3.addr] = 1'b0;
        // byte and dtack held until ds0 is seen high
        for (n = 0; n < 20 && bus3.ds0_n !== 1'b1; n++)
            @(negedge core_clk);
        bus3.data_oe = 1'b0;
        bus3.dtack_oe = 1'b0;
        for (n = 0; n < 20 && bus_req_2 !== 1'b0; n++)
            @(negedge core_clk);
        bus_grant_2 = 1'b0;
        repeat (2) @(negedge core_clk);
    endtask

    // lines 3, 5 and 7 at once: 5 first, then 3, never 7
    task automatic t_rank;
        logic [2:0] lvl;
        @(negedge core_clk);
        bus3.irq_oe = 7'h54;
        serve_subset(lvl);
        check(lvl === 3'h5, "subset top not served first");
        check(status_id_2 === 8'hc5, "wrong byte for top level");
        serve_subset(lvl);
        check(lvl === 3'h3, "lower level not served next");
        check(status_id_2 === 8'hc3, "wrong byte for low level");
        check(ack_level_2 === 3'h3, "wrong level reported");
        check(bus_req_2 === 1'b0, "bus wanted for foreign line");
        bus3.irq_oe = 7'h00;
        $display("test rank done");
    endtask

    // verdict and end of run
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // main sequence
    initial
    begin
        num_errors = 0;
        checks = 0;
        cycles = 0;
        reset = 1'b1;
        req_set = 1'b0;
        req_set_2 = 1'b0;
        stat = 8'h00;
        stat_2 = 8'h00;
        bus_grant = 1'b0;
        bus2.dtb_oe = 1'b0;
        bus2.as_oe = 1'b0;
        bus2.iack_n_o = 1'b1;
        bus2.as_n_o = 1'b1;
        bus2.ds0_n_o = 1'b1;
        bus2.ds1_n_o = 1'b1;
        bus2.write_n_o = 1'b1;
        bus2.addr_o = 3'h7;
        bus_grant_2 = 1'b0;
        bus3.irq_oe = 7'h00;
        bus3.data_o = 8'h00;
        bus3.data_oe = 1'b0;
        bus3.dtack_oe = 1'b0;
        bus3.iackout_n = 1'b1;
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        reset = 1'b0;
        t_single(8'ha5);
        t_single(8'h00);
        t_refuse();
        t_chain();
        t_rank();
        report_and_stop();
    end
endmodule

`default_nettype wire
